// File: pkg/crpr_defs.vh
// Constants for the read-control / previous-set read / return execute block.
// Assumes a 32-bit instruction word with fields at fixed bit positions.
`ifndef CRPR_DEFS_VH
`define CRPR_DEFS_VH

// Instruction field positions
`define CRPR_OP_LSB 0
`define CRPR_OPX_LSB 11
`define CRPR_IDXA_LSB 27
`define CRPR_IDXB_LSB 22
`define CRPR_IDXC_LSB 17
`define CRPR_CONTROL_REGISTER_INDEX_LSB 6
`define CRPR_IMM_LSB 6

// Encodings
`define CRPR_OP_RTYPE 6'h3a
`define CRPR_OP_RDPRS 6'h38
`define CRPR_OPX_RDCTL 6'h26
`define CRPR_OPX_RET 6'h05
`define CRPR_LINK_REG 5'h1f

// Exception causes
`define CRPR_EXC_NONE 2'h0
`define CRPR_EXC_SUPER 2'h1
`define CRPR_EXC_ILLEGAL 2'h2
`define CRPR_EXC_MISALIGN 2'h3

// Reset values
`define CRPR_PRS_RESET 4'h0
`define CRPR_IDX_RESET 5'h00
`define CRPR_WORD_RESET 32'h00000000

`endif

// File: testbench/crpr_props.sv
// Port checker for the execute block.
// Assumes a bind onto crpr_exec in its default build.
`default_nettype none
module crpr_props #(parameter SET_BITS = 4) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Instruction and operands
	input wire logic insn_valid,
	input wire logic [31:0] insn_word,
	input wire logic supervisor,
	input wire logic [31:0] ctl_rd_data,
	input wire logic [31:0] prs_rd_data,
	input wire logic [31:0] link_register,
	// Operand read ports
	input wire logic [4:0] ctl_rd_index,
	input wire logic [SET_BITS-1:0] prs_rd_set,
	input wire logic [4:0] prs_rd_index,
	// Previous-set field
	input wire logic set_switch,
	input wire logic [SET_BITS-1:0] set_current,
	input wire logic prs_wr,
	input wire logic [SET_BITS-1:0] prs_wr_data,
	input wire logic [SET_BITS-1:0] prs_field_q,
	// Results
	input wire logic wb_en_q,
	input wire logic [31:0] wb_data_q,
	input wire logic pc_load_q,
	input wire logic [31:0] pc_target_q,
	input wire logic exc_req_q,
	input wire logic [1:0] exc_cause_q
);
	wire [31:0] w = insn_word;
	wire [31:0] sum = prs_rd_data + {{16{w[21]}}, w[21:6]};
	wire rc = insn_valid && w[5:0] == 6'h3a && w[16:11] == 6'h26 && w[31:22] == 10'h0;
	wire rp = insn_valid && w[5:0] == 6'h38;
	wire rt = insn_valid && w == 32'hf800283a;
	wire ok = link_register[1:0] == 2'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_ctl_copy: assert property (rc && supervisor |=> wb_en_q && wb_data_q == $past(ctl_rd_data))
		else $error("ctl copy");
	chk_ctl_super: assert property (rc && !supervisor |=> exc_req_q && exc_cause_q == 2'h1)
		else $error("ctl mode");
	chk_prs_sum: assert property (rp && supervisor |=> wb_en_q && wb_data_q == $past(sum))
		else $error("prs sum");
	chk_prs_super: assert property (rp && !supervisor |=> exc_req_q && exc_cause_q == 2'h1)
		else $error("prs mode");
	chk_prs_set: assert property (rp |-> prs_rd_set == prs_field_q && prs_rd_index == w[31:27])
		else $error("prs set");
	chk_set_keep: assert property (set_switch |=> prs_field_q == $past(set_current))
		else $error("set keep");
	chk_ret_load: assert property (rt && ok |=> pc_load_q && !wb_en_q && pc_target_q == $past(link_register))
		else $error("ret load");
	chk_ret_align: assert property (rt && !ok |=> exc_req_q && exc_cause_q == 2'h3 && !pc_load_q)
		else $error("ret align");
	chk_prs_write: assert property (prs_wr && !set_switch |=> prs_field_q == $past(prs_wr_data))
		else $error("prs write");
	chk_ctl_index: assert property (rc |-> ctl_rd_index == w[10:6])
		else $error("ctl index");
endmodule
bind crpr_exec crpr_props #(.SET_BITS(SET_BITS)) u_props (.*);
`default_nettype wire

// File: testbench/test_ctl_read_prs_read_return_insns.sv
// Random bench for the execute block.
// Assumes the default build with shadow sets.
`default_nettype none
module test_ctl_read_prs_read_return_insns;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, nrst = 0, insn_valid = 0, supervisor = 0, set_switch = 0, prs_wr = 0;
	logic [31:0] insn_word = 0, ctl_rd_data = 0, prs_rd_data = 0, link_register = 0, w, r, q, l;
	logic [3:0] set_current = 0, prs_wr_data = 0, prs_rd_set, prs_field_q;
	logic [4:0] ctl_rd_index, prs_rd_index, wb_index_q;
	logic wb_en_q, pc_load_q, exc_req_q, hit_q;
	logic [1:0] exc_cause_q;
	logic [31:0] wb_data_q, pc_target_q;
	logic [42:0] e = 0, a;
	logic [3:0] f = 0;
	int errors = 0, num_checks = 0;
	always #5 sys_clk = ~sys_clk;
	crpr_exec uut (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.insn_valid(insn_valid),
		.insn_word(insn_word),
		.supervisor(supervisor),
		.ctl_rd_index(ctl_rd_index),
		.ctl_rd_data(ctl_rd_data),
		.prs_rd_set(prs_rd_set),
		.prs_rd_index(prs_rd_index),
		.prs_rd_data(prs_rd_data),
		.link_register(link_register),
		.set_switch(set_switch),
		.set_current(set_current),
		.prs_wr(prs_wr),
		.prs_wr_data(prs_wr_data),
		.prs_field_q(prs_field_q),
		.wb_en_q(wb_en_q),
		.wb_index_q(wb_index_q),
		.wb_data_q(wb_data_q),
		.pc_load_q(pc_load_q),
		.pc_target_q(pc_target_q),
		.exc_req_q(exc_req_q),
		.exc_cause_q(exc_cause_q),
		.hit_q(hit_q)
	);
	function automatic logic [42:0] expect_of(logic [31:0] w, logic s, logic [31:0] c, p, l);
		if (w[5:0] == 6'h3a && w[16:11] == 6'h26 && w[31:22] == 10'h0)
			return s ? {6'h30, w[21:17], c} : {6'h25, 37'h0};
		if (w[5:0] == 6'h38)
			return s ? {6'h30, w[26:22], p + {{16{w[21]}}, w[21:6]}} : {6'h25, 37'h0};
		if (w == 32'hf800283a)
			return l[1:0] == 2'h0 ? {11'h500, l} : {6'h27, 37'h0};
		return 43'h0;
	endfunction
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h292e));
		repeat (12) @(posedge sys_clk);
		nrst <= 1;
		for (int i = 0; i < 500; i++) begin
			@(posedge sys_clk);
			r = $urandom;
			q = $urandom;
			l = {r[31:2], q[4] ? 2'h0 : r[1:0]};
			// Slot 3 is the most negative offset
			case (i % 5)
				0: w = {10'h0, r[4:0], 6'h26, r[9:5], 6'h3a};
				1: w = {r[31:6], 6'h38};
				2: w = 32'hf800283a;
				3: w = {10'h1f, 16'h8000, 6'h38};
				default: w = r;
			endcase
			{insn_valid, supervisor, set_switch, prs_wr} <= {|q[1:0], |q[3:2], &q[6:5], q[7]};
			{set_current, prs_wr_data, ctl_rd_data, prs_rd_data, link_register, insn_word} <= {q[15:8], r ^ q, q, l, w};
			#1;
			a = {hit_q, wb_en_q, pc_load_q, exc_req_q, exc_cause_q, wb_en_q ? wb_index_q : 5'h0,
				wb_en_q ? wb_data_q : pc_load_q ? pc_target_q : 32'h0};
			num_checks++;
			if (a !== e) begin
				errors++;
				$display("ERROR %0t result mismatch", $time);
			end
			num_checks++;
			if (prs_rd_set !== f || prs_field_q !== f) begin
				errors++;
				$display("ERROR %0t previous-set field mismatch", $time);
			end
			num_checks++;
			if (ctl_rd_index !== w[10:6] || prs_rd_index !== w[31:27]) begin
				errors++;
				$display("ERROR %0t operand index mismatch", $time);
			end
			e = |q[1:0] ? expect_of(w, |q[3:2], r ^ q, q, l) : 43'h0;
			// An exception switch outranks a software write in the same cycle
			f = &q[6:5] ? q[15:12] : q[7] ? q[11:8] : f;
		end
		give_verdict();
	end
endmodule
`default_nettype wire

// File: verilog/crpr_exec.v
// Decode and execute of read-control, previous-set read and return.
// Also holds the previous-set field of the status register for the core.
// Assumes the core presents one instruction per valid cycle with its
// operands already read; results and exceptions are registered one cycle later.
//
// Overview of operation
// - Read-control copies the selected control register into the destination, supervisor-only.
// - Read-control is primary opcode 0x3a, extended 0x26, control index 10..6, dest 21..17, sources zero.
// - Previous-set read adds the sign-extended 16-bit immediate to the previous-set source and writes the current set.
// - The previous set is the one named by the status previous-set field.
// - A set-switching exception leaves the previous-set field holding the set active before it.
// - Without shadow sets previous-set read is illegal; with them it is supervisor-only.
// - Previous-set read is primary opcode 0x38, source 31..27, target 26..22, immediate 21..6.
// - Return loads the PC from the link register and faults on a non-word-aligned target.

`default_nettype none

`include "crpr_defs.vh"

module crpr_exec #(
	parameter SET_BITS = 4,
	parameter HAS_SHADOW = 1
) (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Instruction in
	input wire insn_valid,
	input wire [31:0] insn_word,
	input wire supervisor,
	// Control register read port
	output wire [4:0] ctl_rd_index,
	input wire [31:0] ctl_rd_data,
	// Previous-set operand read port
	output wire [SET_BITS-1:0] prs_rd_set,
	output wire [4:0] prs_rd_index,
	input wire [31:0] prs_rd_data,
	// Link register value of the current set
	input wire [31:0] link_register,
	// Register-set switch by an exception or a software write of the field
	input wire set_switch,
	input wire [SET_BITS-1:0] set_current,
	input wire prs_wr,
	input wire [SET_BITS-1:0] prs_wr_data,
	output reg [SET_BITS-1:0] prs_field_q,
	// Write-back to the current register set
	output reg wb_en_q,
	output reg [4:0] wb_index_q,
	output reg [31:0] wb_data_q,
	// Program counter redirect
	output reg pc_load_q,
	output reg [31:0] pc_target_q,
	// Exception request
	output reg exc_req_q,
	output reg [1:0] exc_cause_q,
	// Recognised-instruction flag
	output reg hit_q
);

	wire [5:0] op;
	wire [5:0] opx;
	wire [4:0] idx_a;
	wire [4:0] idx_b;
	wire [4:0] idx_c;
	wire [15:0] imm;
	wire is_rdctl;
	wire is_rdprs;
	wire is_ret;
	wire [31:0] sum;
	wire [4:0] ctl_idx;
	// Next values of the registered outputs
	reg [SET_BITS-1:0] prs_field_d;
	reg wb_en_d;
	reg [4:0] wb_index_d;
	reg [31:0] wb_data_d;
	reg pc_load_d;
	reg [31:0] pc_target_d;
	reg exc_req_d;
	reg [1:0] exc_cause_d;
	reg hit_d;

	function [31:0] sext16;
		input [15:0] v;
		begin
			sext16 = {{16{v[15]}}, v};
		end
	endfunction

	function misaligned;
		input [31:0] addr;
		begin
			misaligned = addr[1:0] != 2'h0;
		end
	endfunction

	assign op = insn_word[`CRPR_OP_LSB +: 6];
	assign opx = insn_word[`CRPR_OPX_LSB +: 6];
	assign idx_a = insn_word[`CRPR_IDXA_LSB +: 5];
	assign idx_b = insn_word[`CRPR_IDXB_LSB +: 5];
	assign idx_c = insn_word[`CRPR_IDXC_LSB +: 5];
	assign imm = insn_word[`CRPR_IMM_LSB +: 16];
	assign ctl_idx = insn_word[`CRPR_CONTROL_REGISTER_INDEX_LSB +: 5];

	// Either source field set means some other R-type word, so it is not taken
	// read-control match
	assign is_rdctl = insn_valid && op == `CRPR_OP_RTYPE && opx == `CRPR_OPX_RDCTL
		&& idx_a == 5'h00 && idx_b == 5'h00;
	assign is_rdprs = insn_valid && op == `CRPR_OP_RDPRS;
	// return match, link source, no destination
	assign is_ret = insn_valid && op == `CRPR_OP_RTYPE && opx == `CRPR_OPX_RET
		&& idx_a == `CRPR_LINK_REG && idx_b == 5'h00 && idx_c == 5'h00
		&& ctl_idx == 5'h00;

	// control index to the control file
	assign ctl_rd_index = ctl_idx;
	// previous set drives the source read
	assign prs_rd_set = prs_field_q;
	assign prs_rd_index = idx_a;
	assign sum = prs_rd_data + sext16(imm);

	// set switch keeps the outgoing set number
	// A software write loses to a simultaneous exception switch, so a handler
	// always finds the interrupted set in the field.
	always @* begin
		prs_field_d = prs_field_q;
		if (set_switch) begin
			prs_field_d = set_current;
		end else if (prs_wr) begin
			prs_field_d = prs_wr_data;
		end
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prs_field_q <= `CRPR_PRS_RESET;
		end else begin
			prs_field_q <= prs_field_d;
		end
	end

	// Pulses drop by default; index, data and target hold until overwritten
	always @* begin
		wb_en_d = 1'b0;
		wb_index_d = wb_index_q;
		wb_data_d = wb_data_q;
		pc_load_d = 1'b0;
		pc_target_d = pc_target_q;
		exc_req_d = 1'b0;
		exc_cause_d = `CRPR_EXC_NONE;
		// A faulting word still counts as recognised, so the core can trap it
		hit_d = is_rdctl || is_rdprs || is_ret;
		if (is_rdctl) begin
			if (!supervisor) begin
				exc_req_d = 1'b1;
				exc_cause_d = `CRPR_EXC_SUPER;
			end else begin
				wb_en_d = 1'b1;
				wb_index_d = idx_c;
				wb_data_d = ctl_rd_data;
			end
		end else if (is_rdprs) begin
			// illegal without shadow sets, else supervisor-only
			// The build option outranks the mode check, so user code on a core
			// without shadow sets sees the illegal cause.
			if (HAS_SHADOW == 0) begin
				exc_req_d = 1'b1;
				exc_cause_d = `CRPR_EXC_ILLEGAL;
			end else if (!supervisor) begin
				exc_req_d = 1'b1;
				exc_cause_d = `CRPR_EXC_SUPER;
			end else begin
				wb_en_d = 1'b1;
				wb_index_d = idx_b;
				wb_data_d = sum;
			end
		end else if (is_ret) begin
			// jump or misalign fault
			// A faulting return loads nothing and leaves the old target in place.
			if (misaligned(link_register)) begin
				exc_req_d = 1'b1;
				exc_cause_d = `CRPR_EXC_MISALIGN;
			end else begin
				pc_load_d = 1'b1;
				pc_target_d = link_register;
			end
		end
	end

	// Everything clears in reset, so no stray pulse follows its release
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wb_en_q <= 1'b0;
			wb_index_q <= `CRPR_IDX_RESET;
			wb_data_q <= `CRPR_WORD_RESET;
			pc_load_q <= 1'b0;
			pc_target_q <= `CRPR_WORD_RESET;
			exc_req_q <= 1'b0;
			exc_cause_q <= `CRPR_EXC_NONE;
			hit_q <= 1'b0;
		end else begin
			wb_en_q <= wb_en_d;
			wb_index_q <= wb_index_d;
			wb_data_q <= wb_data_d;
			pc_load_q <= pc_load_d;
			pc_target_q <= pc_target_d;
			exc_req_q <= exc_req_d;
			exc_cause_q <= exc_cause_d;
			hit_q <= hit_d;
		end
	end

endmodule

`default_nettype wire
